/* File: hw/beacon_flash_sequencer.sv */
/*
 * Flash sequencer for a rapid_flash_warning_beacon at a crosswalk.
 * Assumes link_in is the wired-OR of link_out of every unit of the
 * crosswalk, this unit included, and arrives asynchronously.
 */
// Overview of operation
// - repeat an exact 800 ms flash cycle
// - twice left, dark, right, dark, 50 ms
// - then both, dark, both, 50 ms each
// - end with 250 ms dark, restart left
// - flash cycle rate outside 5..30 Hz
// - dark when idle, start on actuation
// - stop after the active period elapses
// - active period is a settable input
// - all crosswalk units start, stop together
// - confirmation lamp lit while flashing
module beacon_flash_sequencer
    import beacon_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int unsigned PERIOD_W    = PERIOD_W_DEF
) (
    input  wire logic                clock,         // 250 MHz system clock
    input  wire logic                srst,          // sync reset, active high
    input  wire logic                button,        // pushbutton pin
    input  wire logic [PERIOD_W-1:0] period_ms,     // active period in ms
    input  wire logic                link_in,       // wired-OR crosswalk link
    output logic                     link_out,      // start strobe to link
    output logic                     lamp_left,     // left yellow indication
    output logic                     lamp_right,    // right yellow indication
    output logic                     confirm_lamp   // pedestrian confirmation
);

    generate
        if (PERIOD_W < 1 || PERIOD_W > 32) begin : g_bad_w
            $error("PERIOD_W out of range");
        end
        if (1000 / CYCLE_MS >= FLASH_MIN && 1000 / CYCLE_MS <= FLASH_MAX) begin : g_bad_rate
            $error("flash rate inside forbidden band");
        end
    endgenerate

    logic tick;
    logic press;
    logic start_evt;
    logic tick_clear;

    ms_tick_divider #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock (clock),
        .srst  (srst),
        .clear (tick_clear),
        .tick  (tick)
    );

    button_debounce u_button (
        .clock (clock),
        .srst  (srst),
        .tick  (tick),
        .raw   (button),
        .press (press)
    );

    // link synchroniser, level accepted when stages 2 and 3 agree
    logic [2:0] link_sync_q;
    logic       link_lvl_q, link_lvl_d;

    always_comb begin
        link_lvl_d = (link_sync_q[2] == link_sync_q[1]) ? link_sync_q[1] : link_lvl_q;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            link_sync_q <= '0;
            link_lvl_q  <= 1'b0;
        end else begin
            link_sync_q <= {link_sync_q[1:0], link_in};
            link_lvl_q  <= link_lvl_d;
        end
    end

    // every unit starts on the same link edge, its own included
    assign start_evt = link_lvl_d && !link_lvl_q;

    // outgoing start strobe
    logic [1:0] strobe_q, strobe_d;
    logic       link_out_q, link_out_d;

    always_comb begin
        strobe_d = strobe_q;
        if (press) begin
            strobe_d = STROBE_MS;
        end else if (tick && strobe_q != '0) begin
            strobe_d = strobe_q - 1'b1;
        end
        link_out_d = (strobe_d != '0);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            strobe_q   <= '0;
            link_out_q <= 1'b0;
        end else begin
            strobe_q   <= strobe_d;
            link_out_q <= link_out_d;
        end
    end

    // sequencer state
    seq_state_t          state_q, state_d;
    logic [3:0]          phase_q, phase_d;
    logic [7:0]          ph_ms_q, ph_ms_d;
    logic [PERIOD_W-1:0] remain_q, remain_d;
    lamp_pair_t          lamps_q, lamps_d;
    logic                confirm_q, confirm_d;
    logic                phase_end;

    assign phase_end  = (ph_ms_q == phase_len(phase_q) - 8'h01);
    assign tick_clear = start_evt && (state_q == S_IDLE);

    always_comb begin
        state_d  = state_q;
        phase_d  = phase_q;
        ph_ms_d  = ph_ms_q;
        remain_d = remain_q;
        unique case (state_q)
            S_IDLE: begin
                if (start_evt && period_ms != '0) begin
                    state_d  = S_FLASH;
                    phase_d  = PH_FIRST;
                    ph_ms_d  = '0;
                    remain_d = period_ms;
                end
            end
            S_FLASH: begin
                if (tick) begin
                    // step through phases, wrap each cycle
                    if (phase_end) begin
                        ph_ms_d = '0;
                        // after rest, back to left phase
                        phase_d = (phase_q == PH_REST) ? PH_FIRST : phase_q + 4'h1;
                    end else begin
                        ph_ms_d = ph_ms_q + 8'h01;
                    end
                    remain_d = remain_q - 1'b1;
                end
                if (start_evt && period_ms != '0) begin
                    remain_d = period_ms;
                end else if (tick && remain_q == PERIOD_W'(1)) begin
                    state_d = S_IDLE;
                    phase_d = PH_FIRST;
                    ph_ms_d = '0;
                end
            end
        endcase
        lamps_d   = (state_d == S_FLASH) ? phase_lamps(phase_d) : LAMPS_OFF;
        confirm_d = (state_d == S_FLASH);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q   <= S_IDLE;
            phase_q   <= PH_FIRST;
            ph_ms_q   <= '0;
            remain_q  <= '0;
            lamps_q   <= LAMPS_OFF;
            confirm_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            phase_q   <= phase_d;
            ph_ms_q   <= ph_ms_d;
            remain_q  <= remain_d;
            lamps_q   <= lamps_d;
            confirm_q <= confirm_d;
        end
    end

    assign link_out     = link_out_q;
    assign lamp_left    = lamps_q.left;
    assign lamp_right   = lamps_q.right;
    assign confirm_lamp = confirm_q;

    // cycle length helper, only for checking
    logic [9:0] cyc_ms_q, cyc_ms_d;

    always_comb begin
        cyc_ms_d = cyc_ms_q;
        if (state_q == S_IDLE) begin
            cyc_ms_d = '0;
        end else if (tick) begin
            cyc_ms_d = (phase_end && phase_q == PH_REST) ? 10'h000 : cyc_ms_q + 10'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cyc_ms_q <= '0;
        end else begin
            cyc_ms_q <= cyc_ms_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_cycle_len;
        tick && state_q == S_FLASH && phase_q == PH_REST && phase_end |-> cyc_ms_q == CYCLE_LAST;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("flash cycle not 800 ms");

    property p_wigwag_single;
        state_q == S_FLASH && phase_q < PH_BOTH_FIRST |-> !(lamp_left && lamp_right);
    endproperty
    a_wigwag_single: assert property (p_wigwag_single) else $error("both lamps in wig-wag");

    property p_left_first;
        state_q == S_FLASH && phase_q == PH_FIRST |-> lamp_left && !lamp_right;
    endproperty
    a_left_first: assert property (p_left_first) else $error("cycle not led by left lamp");

    property p_strobe_both;
        state_q == S_FLASH && phase_q == PH_BOTH_FIRST |-> lamp_left && lamp_right;
    endproperty
    a_strobe_both: assert property (p_strobe_both) else $error("strobe not both lamps");

    property p_rest_dark;
        state_q == S_FLASH && phase_q == PH_REST |-> !lamp_left && !lamp_right;
    endproperty
    a_rest_dark: assert property (p_rest_dark) else $error("lamp lit during rest");

    property p_idle_dark;
        state_q == S_IDLE |-> !lamp_left && !lamp_right && !confirm_lamp;
    endproperty
    a_idle_dark: assert property (p_idle_dark) else $error("output lit while idle");

    property p_start;
        state_q == S_IDLE && start_evt && period_ms != '0 |=> state_q == S_FLASH ##0 lamp_left;
    endproperty
    a_start: assert property (p_start) else $error("actuation did not start flashing");

    property p_stop;
        state_q == S_FLASH && tick && remain_q == PERIOD_W'(1) && !start_evt |=> state_q == S_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("flashing outlived the period");

    property p_restart;
        state_q == S_FLASH && start_evt && period_ms != '0 |=> remain_q == $past(period_ms);
    endproperty
    a_restart: assert property (p_restart) else $error("period not restarted");

    property p_confirm;
        confirm_lamp == (state_q == S_FLASH);
    endproperty
    a_confirm: assert property (p_confirm) else $error("confirm lamp disagrees with state");

    property p_press_strobe;
        press |=> link_out ##1 !press;
    endproperty
    a_press_strobe: assert property (p_press_strobe) else $error("press did not drive link");

    property p_press_single;
        press |=> !press [*8];
    endproperty
    a_press_single: assert property (p_press_single) else $error("press not single");

    property p_tick_single;
        tick |=> !tick;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick too wide");

    property p_phase_hold;
        state_q == S_FLASH && !tick |=> state_q == S_FLASH && $stable(phase_q);
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("phase moved without tick");

    property p_zero_period;
        state_q == S_IDLE && period_ms == '0 |=> state_q == S_IDLE;
    endproperty
    a_zero_period: assert property (p_zero_period) else $error("zero period started");

    property p_link_source;
        $rose(link_out) |-> $past(press);
    endproperty
    a_link_source: assert property (p_link_source) else $error("strobe without press");

    property p_remain_step;
        state_q == S_FLASH && tick && !start_evt && remain_q != PERIOD_W'(1)
            |=> remain_q == $past(remain_q) - 1'b1;
    endproperty
    a_remain_step: assert property (p_remain_step) else $error("period count skipped");

endmodule

/* File: hw/beacon_pkg.sv */
/*
 * Shared constants and types for the beacon flash sequencer.
 * Assumes one 250 MHz clock and a synchronous active-high reset.
 */
package beacon_pkg;

    // clock and time base
    localparam int unsigned CLOCK_PERIOD_NS = 4;
    localparam int unsigned MS_NS           = 1000000;
    localparam int unsigned TICK_CYCLES_DEF = MS_NS / CLOCK_PERIOD_NS;

    // flash pattern timing, milliseconds, and flash rate limits in Hz
    localparam logic [7:0] PHASE_MS   = 8'h32;
    localparam logic [7:0] REST_MS    = 8'hFA;
    localparam int unsigned CYCLE_MS  = 800;
    localparam logic [9:0] CYCLE_LAST = 10'h31F;
    localparam int unsigned FLASH_MIN = 5;
    localparam int unsigned FLASH_MAX = 30;

    // phase indices of the twelve-phase wig_wag_strobe_pattern
    localparam logic [3:0] PH_FIRST      = 4'h0;
    localparam logic [3:0] PH_BOTH_FIRST = 4'h8;
    localparam logic [3:0] PH_REST       = 4'hB;

    // button debounce and link strobe lengths, milliseconds
    localparam logic [4:0] DEBOUNCE_MS = 5'h14;
    localparam logic [1:0] STROBE_MS   = 2'h2;

    localparam int unsigned PERIOD_W_DEF = 16;

    typedef enum logic {
        S_IDLE,
        S_FLASH
    } seq_state_t;

    typedef struct packed {
        logic left;
        logic right;
    } lamp_pair_t;

    localparam lamp_pair_t LAMPS_OFF = '{left: 1'b0, right: 1'b0};

    function automatic logic [7:0] phase_len(input logic [3:0] idx);
        return (idx == PH_REST) ? REST_MS : PHASE_MS;
    endfunction

    function automatic lamp_pair_t phase_lamps(input logic [3:0] idx);
        lamp_pair_t l;
        l = LAMPS_OFF;
        case (idx)
            4'h0, 4'h4: l.left = 1'b1;
            4'h2, 4'h6: l.right = 1'b1;
            4'h8, 4'hA: l = '{left: 1'b1, right: 1'b1};
            default: l = LAMPS_OFF;
        endcase
        return l;
    endfunction

endpackage

/* File: hw/ms_tick_divider.sv */
/*
 * Divides the system clock into a one-cycle millisecond tick.
 * Assumes clear comes from logic on the same clock.
 */
module ms_tick_divider
    import beacon_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic clock,  // system clock
    input  wire logic srst,   // sync reset
    input  wire logic clear,  // restart the millisecond
    output logic      tick    // one-cycle pulse per ms
);

    localparam int unsigned CW = $clog2(TICK_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] cnt_q, cnt_d;
    logic          tick_q, tick_d;

    generate
        if (TICK_CYCLES < 2) begin : g_bad
            $error("TICK_CYCLES must be at least 2");
        end
    endgenerate

    always_comb begin
        cnt_d  = (clear || cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        tick_d = !clear && (cnt_q == LAST);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule

/* File: hw/button_debounce.sv */
/*
 * Synchronises and debounces the pedestrian pushbutton, one pulse per press.
 * Assumes a raw pin from outside the clock domain and a ms tick.
 */
module button_debounce
    import beacon_pkg::*;
(
    input  wire logic clock,   // system clock
    input  wire logic srst,    // sync reset
    input  wire logic tick,    // millisecond tick
    input  wire logic raw,     // pushbutton pin, active high
    output logic      press    // one-cycle pulse per press
);

    logic [2:0] sync_q;
    logic [4:0] stab_q, stab_d;
    logic       level_q, level_d;
    logic       press_q, press_d;

    always_comb begin
        stab_d  = stab_q;
        level_d = level_q;
        if (sync_q[2] != sync_q[1] || sync_q[1] == level_q) begin
            stab_d = '0;
        end else if (tick) begin
            stab_d = stab_q + 1'b1;
            if (stab_q == DEBOUNCE_MS - 1'b1) begin
                stab_d  = '0;
                level_d = sync_q[1];
            end
        end
        press_d = level_d && !level_q;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sync_q  <= '0;
            stab_q  <= '0;
            level_q <= 1'b0;
            press_q <= 1'b0;
        end else begin
            sync_q  <= {sync_q[1:0], raw};
            stab_q  <= stab_d;
            level_q <= level_d;
            press_q <= press_d;
        end
    end

    assign press = press_q;

endmodule

/* File: testbench/beacon_partner.sv */
/*
 * Far-side model: the pedestrian pushbutton and one companion crosswalk unit.
 * Assumes the bench ORs peer_link into the crosswalk link and drives tasks.
 */
module beacon_partner #(
    parameter int unsigned TK = 20
) (
    input  wire logic clock,     // system clock
    output logic      button,    // pushbutton pin
    output logic      peer_link  // companion unit strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        button    = 1'b0;
        peer_link = 1'b0;
    end

    task automatic press(input int bounces, input int hold_ms);
        for (int i = 0; i < bounces; i++) begin
            @(negedge clock) button = ~button;
            repeat (TK / 4) @(negedge clock);
        end
        @(negedge clock) button = 1'b1;
        repeat (hold_ms * TK) @(negedge clock);
        button = 1'b0;
    endtask

    // companion start strobe, link pulled low when released
    task automatic peer_strobe();
        @(negedge clock) peer_link = 1'b1;
        repeat (2 * TK) @(negedge clock);
        peer_link = 1'b0;
    endtask
endmodule

/* File: testbench/beacon_flash_sequencer_tb_top.sv */
/*
 * Self-checking bench for the beacon flash sequencer.
 * Assumes a shortened millisecond of TK cycles and a loopback of link_out.
 */
module beacon_flash_sequencer_tb_top
    import beacon_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned TK = 20;

    logic        clock;
    logic        srst;
    logic [15:0] period_ms;
    logic        button;
    logic        peer_link;
    logic        link_in;
    logic        link_out;
    logic        lamp_left;
    logic        lamp_right;
    logic        confirm_lamp;
    logic [7:0]  rises;
    logic        link_q;
    int          err_count;
    int          checks;

    // wired-OR of this unit and the companion
    assign link_in = link_out | peer_link;

    beacon_flash_sequencer #(.TICK_CYCLES(TK), .PERIOD_W(16)) dut_u (
        .clock        (clock),
        .srst         (srst),
        .button       (button),
        .period_ms    (period_ms),
        .link_in      (link_in),
        .link_out     (link_out),
        .lamp_left    (lamp_left),
        .lamp_right   (lamp_right),
        .confirm_lamp (confirm_lamp)
    );

    beacon_partner #(.TK(TK)) partner_u (
        .clock     (clock),
        .button    (button),
        .peer_link (peer_link)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(negedge clock) begin
        link_q <= link_out;
        if (srst) rises <= 8'h00;
        else if (link_out && !link_q) rises <= rises + 8'h01;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_ms(input int ms);
        repeat (ms * TK) @(negedge clock);
    endtask

    task automatic wait_start(input int limit);
        int n;
        n = 0;
        while (confirm_lamp !== 1'b1 && n < limit) begin
            @(negedge clock);
            n++;
        end
    endtask

    function automatic logic [1:0] exp_lamps(input int ms);
        int p;
        p = (ms % 800) / 50;
        case (p)
            0, 4: return 2'h2;
            2, 6: return 2'h1;
            8, 10: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    task automatic t_idle();
        period_ms = 16'h012C;
        partner_u.press(0, 10);
        for (int i = 0; i < 6; i++) begin
            wait_ms(10);
            chk("idle lamps", 8'h00, {5'h00, lamp_left, lamp_right, confirm_lamp});
        end
        chk("glitch strobes", 8'h00, rises);
    endtask

    task automatic t_pattern();
        int el;
        int tgt;
        el = 0;
        period_ms = 16'h03E8;
        fork
            partner_u.peer_strobe();
        join_none
        wait_start(8);
        chk("peer start", 8'h01, {7'h00, confirm_lamp});
        for (int k = 0; k < 17; k++) begin
            tgt = (25 + 50 * k) * TK;
            repeat (tgt - el) @(negedge clock);
            el = tgt;
            chk("pattern", {6'h00, exp_lamps(25 + 50 * k)}, {6'h00, lamp_left, lamp_right});
            chk("confirm on", 8'h01, {7'h00, confirm_lamp});
        end
        wait_ms(150);
        chk("before stop", 8'h01, {7'h00, confirm_lamp});
        wait_ms(50);
        chk("after stop", 8'h00, {5'h00, lamp_left, lamp_right, confirm_lamp});
    endtask

    task automatic t_restart();
        period_ms = 16'h012C;
        fork
            partner_u.press(3, 40);
        join_none
        wait_start(60 * TK);
        chk("button start", 8'h01, {7'h00, confirm_lamp});
        wait_ms(200);
        fork
            partner_u.press(3, 40);
        join_none
        wait_ms(250);
        chk("restarted", 8'h01, {7'h00, confirm_lamp});
        chk("one strobe each", 8'h02, rises);
        wait_ms(110);
        chk("restart stop", 8'h00, {5'h00, lamp_left, lamp_right, confirm_lamp});
    endtask

    task automatic t_zero();
        period_ms = 16'h0000;
        partner_u.peer_strobe();
        wait_ms(50);
        chk("zero period", 8'h00, {5'h00, lamp_left, lamp_right, confirm_lamp});
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        err_count = 0;
        checks    = 0;
        srst      = 1'b1;
        period_ms = 16'h0000;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        t_idle();
        t_pattern();
        t_restart();
        t_zero();
        end_sim();
    end

    initial begin
        repeat (80000) @(posedge clock);
        err_count++;
        end_sim();
    end
endmodule
